// *** logic/flash_spm_pkg.sv ***
// shared constants for the self-programming control block
// assumes both ends are compiled after this package
package flash_spm_pkg;
    // register offset and bit positions
    localparam logic [7:0] CSR_OFFSET = 8'h37;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_RWW_BUSY = 6;
    localparam int BIT_SIG_RD = 5;
    localparam int BIT_RWW_REEN = 4;
    localparam int BIT_BLB_SET = 3;
    localparam int BIT_PG_WRT = 2;
    localparam int BIT_PG_ERS = 1;
    localparam int BIT_SPM_EN = 0;
    // legal low-five-bit command patterns
    localparam logic [4:0] CMD_REEN = 5'h11;
    localparam logic [4:0] CMD_BLB = 5'h09;
    localparam logic [4:0] CMD_WRT = 5'h05;
    localparam logic [4:0] CMD_ERS = 5'h03;
    localparam logic [4:0] CMD_LOAD = 5'h01;
    // signature arm: select bit beside the plain pattern
    localparam logic [5:0] CMD_SIG = 6'h21;
    // arming windows in core cycles
    localparam logic [2:0] SPM_WINDOW = 3'h4;
    localparam logic [2:0] LPM_WINDOW = 3'h3;
    // pointer layout, largest variant: page z15:z8, word z7:z1
    localparam int Z_WIDTH = 16;
    localparam int PAGE_LSB = 8;
    localparam int PAGE_WORDS = 128;
    localparam logic [7:0] RWW_PAGES = 8'he0;
    // boot start words per boot_size_fuse code
    localparam logic [15:0] BOOT_11 = 16'hfe00;
    localparam logic [15:0] BOOT_10 = 16'hfc00;
    localparam logic [15:0] BOOT_01 = 16'hf800;
    localparam logic [15:0] BOOT_00 = 16'hf000;
    // flash operation time, fixed at a neutral figure
    localparam int OP_TIME_US = 4;
    localparam int CLK_MHZ = 125;
    localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
    localparam logic [7:0] LOCK_RESET = 8'hff;
    localparam logic [7:0] FUSE_VALUE = 8'h5a; // arbitrary
    localparam logic [7:0] SIG_VALUE = 8'h3c;  // arbitrary
endpackage : flash_spm_pkg

// *** logic/flash_spm_if.sv ***
// core-to-flash-controller link
// assumes a single 125 mhz core clock shared by both ends
`timescale 1ns/10ps
interface flash_spm_if;
    logic csr_we;
    logic [7:0] csr_wdata;
    logic [7:0] csr_rdata;
    logic spm;
    logic lpm;
    logic [15:0] z_ptr;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] lpm_data;
    logic lpm_valid;
    logic stall;
    logic irq;
    logic global_irq;
    modport device (input csr_we, csr_wdata, spm, lpm, z_ptr, r0, r1,
        global_irq, output csr_rdata, lpm_data, lpm_valid, stall, irq);
    modport core (output csr_we, csr_wdata, spm, lpm, z_ptr, r0, r1,
        global_irq, input csr_rdata, lpm_data, lpm_valid, stall, irq);
endinterface : flash_spm_if

// *** logic/flash_self_program_control.sv ***
// device end: control/status register, arming window, flash sequencing
// assumes the core obeys the stall and keeps one operation in flight
// Functional notes
// RQ1: enable arms store instruction four cycles
// RQ2: plain enable fills page buffer word
// RQ3: erase select erases pointer page
// RQ4: write select programs buffer into page
// RQ5: stall core on halt region operations
// RQ6: enable stays high until operation done
// RQ7: region operation sets busy, blocks reads
// RQ8: busy clears on reenable or load
// RQ9: reenable only after operation finishes
// RQ10: reenable during load discards buffer
// RQ11: lock write takes bits from low data
// RQ12: load within three returns lock/fuse
// RQ13: signature load returns byte, store nothing
// RQ14: ready interrupt while enable clear
// RQ15: only five legal patterns take effect
// RQ16: one operation in flight at once
// RQ17: pointer bit zero selects load byte
// RQ18: mid variant page z14:z7 word z6:z1 (not built here: largest layout only)
// RQ19: large variant page z15:z8 word z7:z1
// RQ20: page is 128 words, word zero
// RQ21: read-while-write region is the low 224 pages
// RQ22: boot fuse selects boot size start
// RQ23: register resets to zero, busy read-only
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
module flash_self_program_control (
    input wire logic i_ref_clk,             // core clock
    input wire logic i_rst_b,               // async reset, active low
    flash_spm_if.device bus,                // core side
    input wire logic [1:0] i_boot_size_fuse, // boot size code
    output logic [15:0] o_boot_start,       // boot reset word address
    output logic o_rww_read_blocked,        // region reads blocked
    output logic [15:0] o_buf_word,         // buffer word at pointer
    output logic o_flash_write,             // one-cycle program pulse
    output logic o_flash_erase,             // one-cycle erase pulse
    output logic [7:0] o_flash_page         // page of last operation
);
    typedef enum {ST_IDLE, ST_BUSY} op_state_e;
    typedef struct packed {
        logic [7:0] csr;
        logic [2:0] win;
        logic [2:0] lwin;
        op_state_e st;
        logic [15:0] cnt;
        logic halt;
        logic loading;
        logic [7:0] lock;
        logic [7:0] lpm_data;
        logic lpm_valid;
        logic fw;
        logic fe;
        logic [7:0] page;
    } state_s;
    state_s q_r, q_nxt;
    logic [15:0] page_buf [flash_spm_pkg::PAGE_WORDS]; // see RQ20
    logic [6:0] widx;
    logic [7:0] zpage;
    logic [4:0] cmd;
    logic in_rww;
    logic buf_we;
    logic buf_clr;
    logic [7:0] wlo;
    logic sig_arm;

    // pointer split, largest variant layout only: the mid variant
    // would take page z14:z7 and word z6:z1, not built here (see RQ18)
    assign widx = bus.z_ptr[7:1];                   // see RQ19 RQ2
    assign zpage = bus.z_ptr[15:flash_spm_pkg::PAGE_LSB];
    assign in_rww = zpage < flash_spm_pkg::RWW_PAGES; // see RQ21
    assign cmd = q_r.csr[4:0];
    assign wlo = bus.csr_wdata;
    // a signature arm shares the plain pattern but must store nothing
    assign sig_arm = q_r.csr[5:0] == flash_spm_pkg::CMD_SIG; // see RQ13
    assign buf_we = bus.spm && q_r.win != 3'h0 && !sig_arm
        && cmd == flash_spm_pkg::CMD_LOAD && q_r.st == ST_IDLE;
    // a reenable write during a load throws the partial page away
    assign buf_clr = bus.csr_we
        && wlo[4:0] == flash_spm_pkg::CMD_REEN && q_r.loading; // see RQ10

    // *****************************
    // sequencer
    // *****************************
    always_comb
    begin
        q_nxt = q_r;
        q_nxt.fw = 1'b0;
        q_nxt.fe = 1'b0;
        q_nxt.lpm_valid = 1'b0;
        // window countdown and timeout
        if (q_r.win != 3'h0 && q_r.st == ST_IDLE)
        begin
            q_nxt.win = q_r.win - 3'h1;
            if (q_r.win == 3'h1)
                q_nxt.csr[5:0] = 6'h00;             // see RQ1 RQ3 RQ4 RQ11
        end
        if (q_r.lwin != 3'h0)
            q_nxt.lwin = q_r.lwin - 3'h1;
        // store instruction inside window; a signature arm ignores it
        if (bus.spm && q_r.win != 3'h0 && q_r.st == ST_IDLE && !sig_arm)
        begin
            q_nxt.win = 3'h0;
            q_nxt.lwin = 3'h0;
            // short commands clear their arm on completion
            q_nxt.csr[5:0] = 6'h00;                 // see RQ1
            if (cmd == flash_spm_pkg::CMD_ERS
                || cmd == flash_spm_pkg::CMD_WRT)
            begin
                // selects stay up so the op's end knows erase from write
                q_nxt.st = ST_BUSY;
                q_nxt.csr[5:0] = q_r.csr[5:0];      // see RQ6 RQ3 RQ4
                q_nxt.cnt = 16'(flash_spm_pkg::OP_CYCLES);
                q_nxt.halt = !in_rww;               // see RQ5
                q_nxt.page = zpage;
                if (in_rww)
                    q_nxt.csr[flash_spm_pkg::BIT_RWW_BUSY] = 1'b1; // see RQ7
                if (cmd == flash_spm_pkg::CMD_WRT)
                    q_nxt.loading = 1'b0;           // buffer consumed
            end
            else if (cmd == flash_spm_pkg::CMD_LOAD)
            begin
                q_nxt.loading = 1'b1;               // see RQ2
                q_nxt.csr[flash_spm_pkg::BIT_RWW_BUSY] = 1'b0; // see RQ8
            end
            else if (cmd == flash_spm_pkg::CMD_REEN)
                q_nxt.csr[flash_spm_pkg::BIT_RWW_BUSY] = 1'b0; // see RQ9 RQ8
            else if (cmd == flash_spm_pkg::CMD_BLB)
                q_nxt.lock = bus.r0;                // see RQ11
        end
        // load instruction reading lock, fuse or signature
        if (bus.lpm && q_r.lwin != 3'h0)
        begin
            q_nxt.lpm_valid = 1'b1;
            if (cmd == flash_spm_pkg::CMD_BLB)      // see RQ12 RQ17
                q_nxt.lpm_data = bus.z_ptr[0] ? flash_spm_pkg::FUSE_VALUE
                                               : q_r.lock;
            else
                q_nxt.lpm_data = flash_spm_pkg::SIG_VALUE; // see RQ13
        end
        // busy countdown, enable held high until done
        if (q_r.st == ST_BUSY)
        begin
            q_nxt.cnt = q_r.cnt - 16'h0001;
            if (q_r.cnt == 16'h0001)
            begin
                q_nxt.st = ST_IDLE;
                q_nxt.halt = 1'b0;
                q_nxt.csr[5:0] = 6'h00;             // see RQ6 RQ3 RQ4
                q_nxt.fe = q_r.csr[flash_spm_pkg::BIT_PG_ERS];
                q_nxt.fw = !q_r.csr[flash_spm_pkg::BIT_PG_ERS];
            end
        end
        if (buf_clr)
            q_nxt.loading = 1'b0;
        // register write: irq enable always, command only if legal and idle
        if (bus.csr_we)
        begin
            q_nxt.csr[flash_spm_pkg::BIT_IRQ_EN] =
                wlo[flash_spm_pkg::BIT_IRQ_EN];
            if (q_r.st == ST_IDLE && !q_r.csr[flash_spm_pkg::BIT_SPM_EN]
                && (wlo[4:0] == flash_spm_pkg::CMD_REEN
                || wlo[4:0] == flash_spm_pkg::CMD_BLB
                || wlo[4:0] == flash_spm_pkg::CMD_WRT
                || wlo[4:0] == flash_spm_pkg::CMD_ERS
                || wlo[4:0] == flash_spm_pkg::CMD_LOAD)) // see RQ15 RQ9
            begin
                // signature select only counts beside the plain pattern
                q_nxt.csr[5:0] = {1'b0, wlo[4:0]};
                if (wlo[5:0] == flash_spm_pkg::CMD_SIG)
                    q_nxt.csr[flash_spm_pkg::BIT_SIG_RD] = 1'b1; // see RQ13
                q_nxt.win = flash_spm_pkg::SPM_WINDOW; // see RQ1
                q_nxt.lwin = (wlo[4:0] == flash_spm_pkg::CMD_BLB
                    || wlo[5:0] == flash_spm_pkg::CMD_SIG)
                    ? flash_spm_pkg::LPM_WINDOW : 3'h0; // see RQ12
            end
            // write bits reach only the select field and irq enable: busy stays hardware's
            q_nxt.csr[flash_spm_pkg::BIT_RWW_BUSY] =
                q_nxt.csr[flash_spm_pkg::BIT_RWW_BUSY]; // see RQ23
        end
    end
    // the erase/write branch above reads the select bits of q_r.csr

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q_r <= '{csr: flash_spm_pkg::CSR_RESET, win: 3'h0, lwin: 3'h0,
                st: ST_IDLE, cnt: 16'h0000, halt: 1'b0, loading: 1'b0,
                lock: flash_spm_pkg::LOCK_RESET, lpm_data: 8'h00,
                lpm_valid: 1'b0, fw: 1'b0, fe: 1'b0, page: 8'h00}; // see RQ23
        end
        else
            q_r <= q_nxt;
    end

    // page buffer: no reset, cleared on abort by rewriting the word
    always_ff @(posedge i_ref_clk)
    begin
        if (buf_we)
            page_buf[widx] <= {bus.r1, bus.r0};     // see RQ2
        else if (buf_clr)
            page_buf[widx] <= 16'hffff;
    end

    // *****************************
    // outputs
    // *****************************
    assign bus.csr_rdata = q_r.csr;
    assign bus.stall = q_r.halt;                    // see RQ5
    assign bus.lpm_data = q_r.lpm_data;
    assign bus.lpm_valid = q_r.lpm_valid;
    assign bus.irq = q_r.csr[flash_spm_pkg::BIT_IRQ_EN] && bus.global_irq
        && !q_r.csr[flash_spm_pkg::BIT_SPM_EN];     // see RQ14
    assign o_rww_read_blocked = q_r.csr[flash_spm_pkg::BIT_RWW_BUSY]; // see RQ7
    assign o_buf_word = q_r.loading ? page_buf[widx] : 16'hffff;
    assign o_flash_write = q_r.fw;
    assign o_flash_erase = q_r.fe;
    assign o_flash_page = q_r.page;

    // boot start per fuse code
    always_comb
    begin
        unique case (i_boot_size_fuse)              // see RQ22
            2'b11: o_boot_start = flash_spm_pkg::BOOT_11;
            2'b10: o_boot_start = flash_spm_pkg::BOOT_10;
            2'b01: o_boot_start = flash_spm_pkg::BOOT_01;
            2'b00: o_boot_start = flash_spm_pkg::BOOT_00;
        endcase
    end
endmodule : flash_self_program_control

// *** logic/flash_spm_core_end.sv ***
// core end: turns plain register-port orders into the timed sequence
// assumes one clock shared with the device end
`timescale 1ns/10ps
module flash_spm_core_end (
    input wire logic i_ref_clk,          // core clock
    input wire logic i_rst_b,            // async reset, active low
    flash_spm_if.core bus,               // device side
    input wire logic [3:0] i_addr,       // user register address
    input wire logic [15:0] i_wdata,     // user write data
    input wire logic i_we,               // write strobe
    input wire logic i_re,               // read strobe
    output logic [15:0] o_rdata          // read data, one cycle later
);
    // user regs: 0 cmd(go), 1 pointer, 2 data, 3 status, 4 irq gate
    typedef enum {CS_IDLE, CS_WAIT, CS_ARM, CS_EXEC} core_state_e;
    typedef struct packed {
        core_state_e st;
        logic [7:0] cmd;
        logic is_load;
        logic [15:0] z;
        logic [15:0] data;
        logic [7:0] result;
        logic gie;
        logic [15:0] rdata;
        logic we;
        logic spm;
        logic lpm;
    } core_s;
    core_s q_r, q_nxt;

    always_comb
    begin
        q_nxt = q_r;
        q_nxt.we = 1'b0;
        q_nxt.spm = 1'b0;
        q_nxt.lpm = 1'b0;
        q_nxt.rdata = 16'h0000;
        if (i_re)
        begin
            unique case (i_addr)
                4'h1: q_nxt.rdata = q_r.z;
                4'h2: q_nxt.rdata = q_r.data;
                4'h3: q_nxt.rdata = {q_r.result, bus.csr_rdata};
                4'h4: q_nxt.rdata = {15'h0000, q_r.gie};
                default: q_nxt.rdata = {15'h0000, q_r.st != CS_IDLE};
            endcase
        end
        if (i_we && q_r.st == CS_IDLE)
        begin
            unique case (i_addr)
                4'h0:
                begin
                    q_nxt.cmd = i_wdata[7:0];
                    q_nxt.is_load = i_wdata[8];
                    q_nxt.st = CS_WAIT;
                end
                4'h1: q_nxt.z = {i_wdata[15:1], 1'b0}; // see RQ17
                4'h2: q_nxt.data = i_wdata;
                4'h4: q_nxt.gie = i_wdata[0];
                default: q_nxt.st = q_r.st;
            endcase
        end
        // one operation at a time: wait for enable to drop first
        unique case (q_r.st)
            CS_IDLE: q_nxt.st = q_nxt.st;
            CS_WAIT:
                if (!bus.csr_rdata[flash_spm_pkg::BIT_SPM_EN] && !bus.stall)
                begin
                    q_nxt.we = 1'b1;                 // see RQ16 RQ9
                    q_nxt.st = CS_ARM;
                end
            CS_ARM:
            begin
                q_nxt.spm = !q_r.is_load;
                q_nxt.lpm = q_r.is_load;             // see RQ12 RQ13
                q_nxt.st = CS_EXEC;
            end
            CS_EXEC:
                if (!q_r.is_load || bus.lpm_valid)
                begin
                    if (q_r.is_load)
                        q_nxt.result = bus.lpm_data;
                    q_nxt.st = CS_IDLE;
                end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            q_r <= '{st: CS_IDLE, cmd: 8'h00, is_load: 1'b0, z: 16'h0000,
                data: 16'h0000, result: 8'h00, gie: 1'b0, rdata: 16'h0000,
                we: 1'b0, spm: 1'b0, lpm: 1'b0};
        else
            q_r <= q_nxt;
    end

    // load pointer bit zero comes from data bit 15, not the user pointer value
    assign bus.csr_we = q_r.we;
    assign bus.csr_wdata = q_r.cmd;
    assign bus.spm = q_r.spm;
    assign bus.lpm = q_r.lpm;
    assign bus.z_ptr = q_r.is_load ? {q_r.z[15:1], q_r.data[15]} : q_r.z;
    assign bus.r0 = q_r.data[7:0];
    assign bus.r1 = q_r.data[15:8];
    assign bus.global_irq = q_r.gie;
    assign o_rdata = q_r.rdata;
endmodule : flash_spm_core_end

// *** tb/flash_spm_props.sv ***
// checker: timing relations on the core-to-device link
// assumes the bench top wires it beside the link instance
`timescale 1ns/10ps
module flash_spm_props (
    input wire logic i_ref_clk,        // core clock
    input wire logic i_rst_b,          // async reset, active low
    input wire logic csr_we,           // register write pulse
    input wire logic [7:0] csr_wdata,  // register write data
    input wire logic [7:0] csr_rdata,  // register contents
    input wire logic spm,              // store instruction
    input wire logic lpm,              // load instruction
    input wire logic lpm_valid,        // load answer
    input wire logic stall,            // core halt
    input wire logic irq,              // ready request
    input wire logic global_irq        // core interrupt enable
);
    localparam int OP_MIN = flash_spm_pkg::OP_CYCLES - 5;
    logic legal;
    logic [9:0] hold_r;
    logic [9:0] hold_nxt;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // ****************
    // helper logic
    // ****************
    assign legal = csr_wdata[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01};
    // the op hold is far too long to unroll, so count it
    always_comb hold_nxt = csr_rdata[0] ? hold_r + 10'h001 : 10'h000;
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
        if (!i_rst_b) hold_r <= 10'h000;
        else hold_r <= hold_nxt;
    // ****************
    // assertions
    // ****************
    AST_ARM: assert property (
        csr_we && !csr_rdata[0] && legal |=> csr_rdata[0])
        else $error("legal idle write did not arm");
    AST_REFUSE: assert property (
        csr_we && !csr_rdata[0] && !legal |=> $stable(csr_rdata[5:0]))
        else $error("illegal pattern changed the register");
    AST_IRQ: assert property (
        irq == (csr_rdata[7] && global_irq && !csr_rdata[0]))
        else $error("ready request level wrong");
    AST_STALL: assert property (
        $rose(stall) |-> csr_rdata[2:1] != 2'b00 ##1 stall [*8])
        else $error("stall outside erase or write");
    AST_BUSY_SET: assert property (
        $rose(csr_rdata[6]) |-> csr_rdata[2:1] != 2'b00)
        else $error("busy flag set without erase or write");
    AST_BUSY_KEEP: assert property (
        csr_rdata[6] && !spm ##1 !spm |=> csr_rdata[6])
        else $error("busy flag dropped with no store");
    AST_HOLD: assert property (
        $fell(csr_rdata[0]) && $past(csr_rdata[2:1]) != 2'b00
        |-> $past(hold_r) >= OP_MIN)
        else $error("enable dropped before op finished");
    AST_SEL_CLR: assert property (
        $fell(csr_rdata[0]) |-> csr_rdata[4:1] == 4'h0)
        else $error("select bits left set after op");
    AST_LPM: assert property (
        lpm |=> lpm_valid ##1 !lpm_valid)
        else $error("load answer not a one-cycle pulse");
endmodule : flash_spm_props

// *** tb/flash_self_program_control_tb.sv ***
// bench: drives the core end's register port, watches both ends
// assumes one clock and one reset shared by both ends and the link
`timescale 1ns/10ps
module flash_self_program_control_tb;
    logic i_ref_clk;
    logic i_rst_b;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
    logic [15:0] rdata;
    logic [1:0] fuse;
    logic [15:0] boot_start;
    logic blocked;
    logic [15:0] buf_word;
    logic fw;
    logic fe;
    logic [7:0] page;
    logic [15:0] d;
    logic [7:0] last_pg;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_wr = 0;
    int n_er = 0;
    int cyc = 0;
    logic [15:0] boot_tab [4];
    logic [15:0] bad_tab [4];
    flash_spm_if ifc ();
    flash_self_program_control flash_self_program_control_i (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .bus(ifc),
        .i_boot_size_fuse(fuse), .o_boot_start(boot_start),
        .o_rww_read_blocked(blocked), .o_buf_word(buf_word),
        .o_flash_write(fw), .o_flash_erase(fe), .o_flash_page(page));
    flash_spm_core_end flash_spm_core_end_i (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .bus(ifc),
        .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re),
        .o_rdata(rdata));
    flash_spm_props flash_spm_props_i (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .csr_we(ifc.csr_we),
        .csr_wdata(ifc.csr_wdata), .csr_rdata(ifc.csr_rdata),
        .spm(ifc.spm), .lpm(ifc.lpm), .lpm_valid(ifc.lpm_valid),
        .stall(ifc.stall), .irq(ifc.irq), .global_irq(ifc.global_irq));
    // ****************
    // tasks
    // ****************
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_ref_clk);
        we <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge i_ref_clk);
        we <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge i_ref_clk);
        re <= 1'b1;
        addr <= a;
        @(posedge i_ref_clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // bounded wait: core end idle and no operation armed
    task automatic idle();
        int k;
        k = 0;
        rd(4'h0);
        while ((d !== 16'h0000 || ifc.csr_rdata[0] !== 1'b0) && k < 1000)
        begin
            rd(4'h0);
            k++;
        end
        if (k == 1000) n_mismatch++;
    endtask : idle
    // 20 cycles lands well inside the flash operation time
    task automatic start(input logic [15:0] z, input logic [15:0] c);
        wr(4'h1, z);
        wr(4'h0, c);
        repeat (20) @(posedge i_ref_clk);
        #1;
    endtask : start
    task automatic op(input logic [15:0] z, input logic [15:0] c);
        wr(4'h1, z);
        wr(4'h0, c);
        idle();
    endtask : op
    // ****************
    // clock, pulse monitor, timeout
    // ****************
    initial
    begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (fw === 1'b1) n_wr++;
        if (fe === 1'b1) n_er++;
        if (fw === 1'b1 || fe === 1'b1) last_pg = page;
        if (cyc == 30000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    // ****************
    // main sequence
    // ****************
    initial
    begin
        i_rst_b = 1'b0;
        we = 1'b0;
        re = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        fuse = 2'h0;
        boot_tab = '{flash_spm_pkg::BOOT_00, flash_spm_pkg::BOOT_01,
            flash_spm_pkg::BOOT_10, flash_spm_pkg::BOOT_11};
        bad_tab = '{16'h0007, 16'h000f, 16'h0013, 16'h0019};
        repeat (5) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        rd(4'h3);
        chk(d & 16'h00ff, 16'h0000);
        chk(16'(ifc.irq), 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge i_ref_clk);
            fuse <= i[1:0];
            @(posedge i_ref_clk);
            #1 chk(boot_start, boot_tab[i]);
        end
        // pointer lsb set on purpose: it must be ignored
        wr(4'h2, 16'h1234);
        op(16'h0005, 16'h0001);
        chk(buf_word, 16'h1234);
        start(16'hdf80, 16'h0003);
        chk(16'(blocked), 16'h0001);
        chk(16'(ifc.stall), 16'h0000);
        rd(4'h3);
        chk(d & 16'h00ff, 16'h0043);
        idle();
        chk(16'(n_er), 16'h0001);
        chk(16'(last_pg), 16'h00df);
        rd(4'h3);
        chk(d & 16'h00ff, 16'h0040);
        op(16'h0000, 16'h0011);
        chk(16'(blocked), 16'h0000);
        op(16'h1000, 16'h0003);
        wr(4'h2, 16'habcd);
        op(16'h0005, 16'h0001);
        chk(16'(blocked), 16'h0000);
        chk(buf_word, 16'habcd);
        op(16'h0005, 16'h0011);
        chk(buf_word, 16'hffff);
        start(16'he000, 16'h0005);
        chk(16'(ifc.stall), 16'h0001);
        chk(16'(blocked), 16'h0000);
        idle();
        chk(16'(n_wr), 16'h0001);
        chk(16'(last_pg), 16'h00e0);
        for (int i = 0; i < 4; i++)
        begin
            op(16'h0000, bad_tab[i]);
            rd(4'h3);
            chk(d & 16'h00ff, 16'h0000);
        end
        chk(16'(n_er + n_wr), 16'h0003);
        // data bit 15 picks fuse (1) or lock (0) on a load
        wr(4'h2, 16'h8000);
        op(16'h0001, 16'h0109);
        rd(4'h3);
        chk(d >> 8, {8'h00, flash_spm_pkg::FUSE_VALUE});
        wr(4'h2, 16'h0000);
        op(16'h0000, 16'h0109);
        rd(4'h3);
        chk(d >> 8, {8'h00, flash_spm_pkg::LOCK_RESET});
        wr(4'h2, 16'h00f3);
        op(16'h0000, 16'h0009);
        op(16'h0000, 16'h0109);
        rd(4'h3);
        chk(d >> 8, 16'h00f3);
        op(16'h0000, 16'h0121);
        rd(4'h3);
        chk(d >> 8, {8'h00, flash_spm_pkg::SIG_VALUE});
        wr(4'h4, 16'h0001);
        op(16'h0000, 16'h0080);
        chk(16'(ifc.irq), 16'h0001);
        start(16'h1000, 16'h0083);
        chk(16'(ifc.irq), 16'h0000);
        idle();
        chk(16'(ifc.irq), 16'h0001);
        end_of_test();
    end
endmodule : flash_self_program_control_tb
